// ===== src/smq_pkg.sv
// constants, register map and carrier types of the status and message queues
// assumes a single 25 MHz clock and an APB master with 32-bit data
package smq_pkg;

   // register byte offsets on the APB
   localparam logic [7:0] SMQ_OFF_STB      = 8'h00;
   localparam logic [7:0] SMQ_OFF_SRE      = 8'h04;
   localparam logic [7:0] SMQ_OFF_OUTQ     = 8'h08;
   localparam logic [7:0] SMQ_OFF_ERRQ     = 8'h0c;
   localparam logic [7:0] SMQ_OFF_FRANGE   = 8'h10;
   localparam logic [7:0] SMQ_OFF_FCTRL    = 8'h14;
   localparam logic [7:0] SMQ_OFF_CMD      = 8'h18;
   localparam logic [7:0] SMQ_OFF_MEVT     = 8'h1c;
   localparam logic [7:0] SMQ_OFF_MEN      = 8'h20;
   localparam logic [7:0] SMQ_OFF_AVG      = 8'h24;

   // status byte bit positions
   localparam int unsigned SMQ_STB_MEAS = 0;
   localparam int unsigned SMQ_STB_ERDY = 2;
   localparam int unsigned SMQ_STB_MRDY = 4;
   localparam int unsigned SMQ_STB_RQS  = 6;

   // command register bits
   localparam int unsigned SMQ_CMD_CLS    = 0;
   localparam int unsigned SMQ_CMD_PRESET = 1;

   // measurement event bit for battery buffer full
   localparam int unsigned SMQ_MEAS_BATFULL = 9;

   // error queue geometry and fixed codes
   localparam logic [3:0]  SMQ_ERRQ_DEPTH = 4'ha;
   localparam logic [3:0]  SMQ_ERRQ_LAST  = 4'h9;
   localparam logic [15:0] SMQ_CODE_OVF   = 16'h015e;
   localparam logic [15:0] SMQ_CODE_NONE  = 16'h0000;

   // reset values
   localparam logic [7:0]  SMQ_SRE_RST  = 8'h00;
   localparam logic [15:0] SMQ_MEN_RST  = 16'h0000;
   localparam logic [15:0] SMQ_AVG_RST  = 16'h0001;

   // filter programming operations, written to the low bits of FCTRL
   typedef enum logic [1:0] {
      SMQ_OP_NONE,
      SMQ_OP_ENLIST,
      SMQ_OP_ENADD,
      SMQ_OP_DISADD
   } smq_fop_e;

   // one inclusive range of signed codes
   typedef struct packed {
      logic signed [15:0] hi;
      logic signed [15:0] lo;
   } smq_range_s;

   // one error or status event offered to the error queue
   typedef struct packed {
      logic        isStatus;
      logic [15:0] code;
   } smq_err_s;

endpackage

// ===== src/smq_status_queues.sv
// output queue, error queue with code filter, status byte and measurement event
// assumes APB master on mclk and event sources on the same clock
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - pushing a response into the output queue sets message-ready
// - reading the output queue register removes the message read
// - message-ready clears once the output queue is empty
// - an admitted error or status event pushes its code into error queue
// - any entry entering the error queue sets error-ready
// - error queue read returns oldest entry, then removes it
// - error-ready clears once the error queue is empty
// - the error queue never holds more than ten entries
// - filling the last slot stores overflow code 350 instead
// - after reset the error queue is empty
// - reading an empty error queue returns code 0
// - entries are signed codes, negative standard, positive vendor
// - after reset errors are admitted and status messages are not
// - an enable list admits only listed codes
// - a disable list removes listed codes, others unchanged
// - an empty enable list blocks every message
// - lists mix single codes and inclusive ranges
// - reset and clear-status empty the queue; preset leaves it alone
// - filter settings restored only by reset
// - service-request enable bit 4 raises a request when a message waits
// - battery buffer full sets measurement bit 9 after averaging count
// - event register read clears it; clear-status clears event registers
module smq_status_queues #(
   parameter int unsigned OUTQ_DEPTH = 8,
   parameter int unsigned NUM_RANGES = 4
) (
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              rst_n,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // response messages from the command parser
   input  wire logic              rspValid,
   input  wire logic [31:0]       rspData,
   output logic                   rspReady,
   // error and status events
   input  wire logic              errEvtValid,
   input  wire smq_pkg::smq_err_s errEvt,
   // battery channel reading completed
   input  wire logic              batReadingDone,
   // status outputs
   output logic                   messageReadyFlag,
   output logic                   errorReadyFlag,
   output logic                   batteryBufferFullFlag,
   output logic                   srq
);
   import smq_pkg::*;

   localparam int unsigned OAW = $clog2(OUTQ_DEPTH);

   // range hit across a table of ranges; used for both lists
   function automatic logic rangeHit(input smq_range_s tbl [NUM_RANGES],
                                     input logic [NUM_RANGES-1:0] vld,
                                     input logic signed [15:0] code);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < NUM_RANGES; i++) begin
         if (vld[i] && code >= tbl[i].lo && code <= tbl[i].hi) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction

   // apb address decode; used only for the error answer
   function automatic logic regMapped(input logic [7:0] a);
      return a == SMQ_OFF_STB || a == SMQ_OFF_SRE || a == SMQ_OFF_OUTQ ||
             a == SMQ_OFF_ERRQ || a == SMQ_OFF_FRANGE || a == SMQ_OFF_FCTRL ||
             a == SMQ_OFF_CMD || a == SMQ_OFF_MEVT || a == SMQ_OFF_MEN ||
             a == SMQ_OFF_AVG;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // bus phases
   logic access;
   logic setupRd;
   logic wrAcc;
   logic clsCmd;
   logic presetCmd;
   logic rdOutOk;
   logic rdErrOk;

   assign access    = psel & penable;
   assign setupRd   = psel & ~penable & ~pwrite;
   assign wrAcc     = access & pwrite;
   assign pready    = 1'b1;  // every register answers in the first access cycle
   assign pslverr   = access & ~regMapped(paddr);
   assign clsCmd    = wrAcc && paddr == SMQ_OFF_CMD && pwdata[SMQ_CMD_CLS];
   assign presetCmd = wrAcc && paddr == SMQ_OFF_CMD && pwdata[SMQ_CMD_PRESET];

   ////////////////////////////////////////////////////////////////////////////
   // output queue storage
   logic [31:0]  outMem [OUTQ_DEPTH];
   logic [OAW-1:0] outWr;
   logic [OAW-1:0] outRd;
   logic [OAW:0]   outCount;
   logic           outPush;
   logic           outPop;

   assign rspReady = outCount != (OAW+1)'(OUTQ_DEPTH);
   assign outPush  = rspValid & rspReady;
   // pop only what the setup cycle actually returned
   assign outPop   = access && !pwrite && paddr == SMQ_OFF_OUTQ && rdOutOk;

   // queue write side
   always_ff @(posedge mclk) begin
      if (outPush) begin
         outMem[outWr] <= rspData;
      end
   end

   // pointers and occupancy
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         outWr    <= '0;
         outRd    <= '0;
         outCount <= '0;
      end else begin
         if (outPush) begin
            outWr <= (outWr == OAW'(OUTQ_DEPTH-1)) ? '0 : outWr + 1'b1;
         end
         if (outPop) begin
            outRd <= (outRd == OAW'(OUTQ_DEPTH-1)) ? '0 : outRd + 1'b1;
         end
         outCount <= outCount + (OAW+1)'(outPush) - (OAW+1)'(outPop);
      end
   end

   assign messageReadyFlag = outCount != '0;

   ////////////////////////////////////////////////////////////////////////////
   // error code filter
   smq_range_s          enTbl  [NUM_RANGES];
   smq_range_s          disTbl [NUM_RANGES];
   logic [NUM_RANGES-1:0] enVld;
   logic [NUM_RANGES-1:0] disVld;
   logic                defaultMode;
   smq_range_s          rangeReg;
   smq_fop_e            fop;
   logic                admit;

   assign fop = smq_fop_e'(pwdata[1:0]);

   // admission: default admits errors only, a list admits listed codes
   always_comb begin
      if (defaultMode) begin
         admit = !errEvt.isStatus;
      end else begin
         admit = rangeHit(enTbl, enVld, errEvt.code);
      end
      if (rangeHit(disTbl, disVld, errEvt.code)) begin
         admit = 1'b0;
      end
   end

   // staging register for one range written before its op
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rangeReg <= '0;
      end else if (wrAcc && paddr == SMQ_OFF_FRANGE) begin
         rangeReg <= pwdata;
      end
   end

   // list tables; only reset and FCTRL writes touch them, not clear-status or preset
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         defaultMode <= 1'b1;
         enVld       <= '0;
         disVld      <= '0;
         for (int i = 0; i < NUM_RANGES; i++) begin
            enTbl[i]  <= '0;
            disTbl[i] <= '0;
         end
      end else if (wrAcc && paddr == SMQ_OFF_FCTRL) begin
         unique case (fop)
            SMQ_OP_NONE: begin
            end
            SMQ_OP_ENLIST: begin
               // a new enable list replaces the whole enabled set
               defaultMode <= 1'b0;
               enVld       <= '0;
               disVld      <= '0;
            end
            SMQ_OP_ENADD: begin
               // slots beyond the table size are silently ignored
               for (int i = NUM_RANGES - 1; i >= 0; i--) begin
                  if (!enVld[i]) begin
                     enTbl[i] <= rangeReg;
                  end
               end
               enVld <= {enVld[NUM_RANGES-2:0], 1'b1};
            end
            SMQ_OP_DISADD: begin
               for (int i = NUM_RANGES - 1; i >= 0; i--) begin
                  if (!disVld[i]) begin
                     disTbl[i] <= rangeReg;
                  end
               end
               disVld <= {disVld[NUM_RANGES-2:0], 1'b1};
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // error queue, ten signed codes
   logic [15:0] errMem [SMQ_ERRQ_DEPTH];
   logic [3:0]  errWr;
   logic [3:0]  errRd;
   logic [3:0]  errCount;
   logic [3:0]  errEff;
   logic        errPop;
   logic        errPush;
   logic [15:0] pushCode;
   logic [3:0]  wrBase;
   logic [3:0]  rdBase;

   // pop only what the setup cycle actually returned
   assign errPop   = access && !pwrite && paddr == SMQ_OFF_ERRQ && rdErrOk && !clsCmd;
   // occupancy once any pop or clear-status of this cycle is counted
   assign errEff   = clsCmd ? 4'h0 : errCount - 4'(errPop);
   assign errPush  = errEvtValid && admit && errEff != SMQ_ERRQ_DEPTH;
   assign pushCode = (errEff == SMQ_ERRQ_LAST) ? SMQ_CODE_OVF : errEvt.code;
   assign wrBase   = clsCmd ? 4'h0 : errWr;
   assign rdBase   = clsCmd ? 4'h0 : errRd;

   always_ff @(posedge mclk) begin
      if (errPush) begin
         errMem[wrBase] <= pushCode;
      end
   end

   // clear-status empties the queue but a coincident event is still kept
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         errWr    <= 4'h0;
         errRd    <= 4'h0;
         errCount <= 4'h0;
      end else begin
         errWr <= errPush ? ((wrBase == SMQ_ERRQ_LAST) ? 4'h0 : wrBase + 4'h1) : wrBase;
         errRd <= errPop ? ((rdBase == SMQ_ERRQ_LAST) ? 4'h0 : rdBase + 4'h1) : rdBase;
         errCount <= errEff + 4'(errPush);
      end
   end

   assign errorReadyFlag = errCount != 4'h0;

   ////////////////////////////////////////////////////////////////////////////
   // measurement event set, averaging and enable
   logic [15:0] measEvt;
   logic [15:0] measEn;
   logic [15:0] avgCount;
   logic [15:0] batCount;
   logic        batFullSet;
   logic [15:0] evtClr;

   // a count of zero behaves as one
   assign batFullSet = batReadingDone &&
                       (batCount + 16'h1 >= avgCount);
   // read clears only the bits captured at setup, so late sets survive
   assign evtClr = clsCmd ? 16'hffff :
                   (access && !pwrite && paddr == SMQ_OFF_MEVT) ? prdata[15:0] : 16'h0000;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         batCount <= 16'h0000;
      end else if (batReadingDone) begin
         batCount <= batFullSet ? 16'h0000 : batCount + 16'h1;
      end
   end

   // event register, set wins over clear
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         measEvt <= 16'h0000;
      end else begin
         measEvt <= (measEvt & ~evtClr) | (16'(batFullSet) << SMQ_MEAS_BATFULL);
      end
   end

   // measurement enable, cleared by preset too
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         measEn <= SMQ_MEN_RST;
      end else if (presetCmd) begin
         measEn <= SMQ_MEN_RST;
      end else if (wrAcc && paddr == SMQ_OFF_MEN) begin
         measEn <= pwdata[15:0];
      end
   end

   // averaging count
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         avgCount <= SMQ_AVG_RST;
      end else if (wrAcc && paddr == SMQ_OFF_AVG) begin
         avgCount <= pwdata[15:0];
      end
   end

   assign batteryBufferFullFlag = measEvt[SMQ_MEAS_BATFULL];

   ////////////////////////////////////////////////////////////////////////////
   // status byte and service request
   logic [7:0] sre;
   logic [7:0] stb;

   always_comb begin
      stb               = 8'h00;
      stb[SMQ_STB_MEAS] = |(measEvt & measEn);
      stb[SMQ_STB_ERDY] = errorReadyFlag;
      stb[SMQ_STB_MRDY] = messageReadyFlag;
      stb[SMQ_STB_RQS]  = srq;
   end

   // request enable; the request bit itself never gates itself
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sre <= SMQ_SRE_RST;
      end else if (wrAcc && paddr == SMQ_OFF_SRE) begin
         sre <= pwdata[7:0];
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         srq <= 1'b0;
      end else begin
         srq <= |(stb & sre & ~(8'h01 << SMQ_STB_RQS));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data captured in the setup cycle, popped in the access cycle
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         prdata  <= 32'h0000_0000;
         rdOutOk <= 1'b0;
         rdErrOk <= 1'b0;
      end else if (setupRd) begin
         rdOutOk <= paddr == SMQ_OFF_OUTQ && outCount != '0;
         rdErrOk <= paddr == SMQ_OFF_ERRQ && errCount != 4'h0;
         prdata  <= 32'h0000_0000;
         unique case (paddr)
            SMQ_OFF_STB:  prdata <= {16'h0000, 4'h0, errCount, stb};
            SMQ_OFF_SRE:  prdata <= {24'h00_0000, sre};
            SMQ_OFF_OUTQ: prdata <= (outCount != '0) ? outMem[outRd] : 32'h0000_0000;
            SMQ_OFF_ERRQ: prdata <= (errCount != 4'h0) ?
                                    {{16{errMem[errRd][15]}}, errMem[errRd]} :
                                    {16'h0000, SMQ_CODE_NONE};
            SMQ_OFF_FRANGE: prdata <= rangeReg;
            SMQ_OFF_FCTRL:  prdata <= {31'h0000_0000, defaultMode};
            SMQ_OFF_MEVT: prdata <= {16'h0000, measEvt};
            SMQ_OFF_MEN:  prdata <= {16'h0000, measEn};
            SMQ_OFF_AVG:  prdata <= {16'h0000, avgCount};
            default:      prdata <= 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   mready_push_a: assert property (@(posedge mclk) disable iff (!rst_n)
      outPush |=> messageReadyFlag)
      else $error("message ready not set after push");

   mready_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (outPop && outCount == 1 && !outPush) |=> !messageReadyFlag)
      else $error("message ready stuck after last read");

   eready_push_a: assert property (@(posedge mclk) disable iff (!rst_n)
      errPush |=> errorReadyFlag && errCount == $past(errEff) + 4'h1)
      else $error("error ready or count wrong after push");

   errq_bound_a: assert property (@(posedge mclk) disable iff (!rst_n)
      errCount <= SMQ_ERRQ_DEPTH)
      else $error("error queue over ten entries");

   overflow_slot_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (errPush && errEff == SMQ_ERRQ_LAST) |=> errMem[$past(wrBase)] == SMQ_CODE_OVF)
      else $error("last slot does not hold overflow code");

   empty_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (setupRd && paddr == SMQ_OFF_ERRQ && errCount == 4'h0) |=> prdata == 32'h0)
      else $error("empty error queue read not zero");

   full_drop_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (errCount == SMQ_ERRQ_DEPTH && !errPop && !clsCmd) |=> errCount == SMQ_ERRQ_DEPTH)
      else $error("full error queue changed without read");

   cls_empty_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (clsCmd && !errPush) |=> errCount == 4'h0 && !errorReadyFlag)
      else $error("clear-status left entries");

   srq_mready_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (sre[SMQ_STB_MRDY] && messageReadyFlag) |=> srq)
      else $error("no service request for waiting message");

   batfull_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
      batFullSet |=> measEvt[SMQ_MEAS_BATFULL] && batCount == 16'h0)
      else $error("buffer full bit not set at averaging count");

endmodule

// ===== dv/smq_host.sv
// host model: apb master that reads instrument messages
// assumes one clock shared with the queues; bench calls its tasks in turn
`timescale 1ns/1ps
module smq_host
   import smq_pkg::*;
(
   // clock
   input  wire logic        mclk,
   // apb master side
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   ////////////////////////////////////////
   // idle bus from time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end

   // one transfer; request held until pready is seen high at an edge, for at most 50 edges
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err, output logic to);
      int n;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge mclk);
         if (pready === 1'b1) break;
      end
      rd = prdata;
      err = pslverr;
      to = (n == 50);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // poll the event register, up to twenty reads, until the buffer-full bit is set
   task automatic pollFull(output logic [31:0] v, output logic to);
      logic e;
      int k;
      for (k = 0; k < 20; k++) begin
         xfer(1'b0, SMQ_OFF_MEVT, 32'h0, v, e, to);
         if (to || v[SMQ_MEAS_BATFULL]) break;
      end
      to = to || (k == 20);
   endtask
endmodule

// ===== dv/smq_status_queues_bench.sv
// self-checking bench for the status and message queues
// assumes the host model drives apb; bench drives responses and events
`timescale 1ns/1ps
module smq_status_queues_bench;
   import smq_pkg::*;
   logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rspData, r;
   logic        rspValid, rspReady, errEvtValid, batReadingDone, e, to;
   logic        messageReadyFlag, errorReadyFlag, batteryBufferFullFlag, srq;
   smq_err_s    errEvt;
   int          failures, compares, i;
   typedef struct {logic [7:0] a; logic [31:0] d; logic e;} smq_row_s;
   // reset values of every register but FRANGE and CMD, plus one unmapped hole
   smq_row_s rows[9] = '{'{SMQ_OFF_STB, 0, 0}, '{SMQ_OFF_SRE, 0, 0}, '{SMQ_OFF_OUTQ, 0, 0},
      '{SMQ_OFF_ERRQ, 0, 0}, '{SMQ_OFF_FCTRL, 1, 0}, '{SMQ_OFF_MEVT, 0, 0},
      '{SMQ_OFF_MEN, 0, 0}, '{SMQ_OFF_AVG, 1, 0}, '{8'h28, 0, 1}};

   smq_status_queues u_dut (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .rspValid, .rspData, .rspReady, .errEvtValid, .errEvt,
      .batReadingDone, .messageReadyFlag, .errorReadyFlag, .batteryBufferFullFlag, .srq);
   smq_host u_host (.mclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr);

   ////////////////////////////////////////
   // 25 mhz clock
   initial mclk = 1'b0;
   always #20 mclk = ~mclk;

   task automatic conclude();
      $display("compares=%0d failures=%0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic hang();
      failures++;
      $display("CHECK FAILED %0t wait ran out", $time);
      conclude();
   endtask
   task automatic chk32(input logic [31:0] g, input logic [31:0] x);
      compares++;
      if (g !== x) begin
         failures++;
         $display("CHECK FAILED %0t got %h expected %h", $time, g, x);
      end
   endtask
   task automatic chk1(input logic g, input logic x);
      compares++;
      if (g !== x) begin
         failures++;
         $display("CHECK FAILED %0t flag %b expected %b", $time, g, x);
      end
   endtask
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
      u_host.xfer(w, a, d, r, e, to);
      if (to) hang();
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      acc(1'b0, a, 32'h0);
      chk32(r, x);
   endtask
   // one event pulse; ends low so the next call starts a cycle later
   task automatic evt(input logic s, input logic [15:0] c);
      @(posedge mclk);
      errEvtValid <= 1'b1;
      errEvt <= '{isStatus: s, code: c};
      @(posedge mclk);
      errEvtValid <= 1'b0;
   endtask
   task automatic rsp(input logic [31:0] d);
      int n;
      logic ok;
      @(posedge mclk);
      rspValid <= 1'b1;
      rspData <= d;
      for (n = 0; n < 50; n++) begin
         @(negedge mclk);
         ok = rspReady;
         @(posedge mclk);
         if (ok === 1'b1) break;
      end
      rspValid <= 1'b0;
      if (n == 50) hang();
   endtask
   task automatic pulse(input int k);
      repeat (k) begin
         @(posedge mclk);
         batReadingDone <= 1'b1;
         @(posedge mclk);
         batReadingDone <= 1'b0;
      end
      repeat (2) @(negedge mclk);
   endtask
   function automatic logic [31:0] sx(input logic [15:0] c);
      return {{16{c[15]}}, c};
   endfunction

   ////////////////////////////////////////
   initial begin
      {rst_n, rspValid, errEvtValid, batReadingDone} = 4'h0;
      rspData = 32'h0;
      errEvt = '0;
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      // reset values and unmapped access
      foreach (rows[k]) begin
         acc(1'b0, rows[k].a, 32'h0);
         chk32(r, rows[k].d);
         chk1(e, rows[k].e);
      end
      // output queue with service request on message-ready
      acc(1'b1, SMQ_OFF_SRE, 32'h10);
      rd(SMQ_OFF_SRE, 32'h10);
      rsp(32'h11);
      rsp(32'h22);
      repeat (2) @(negedge mclk);
      chk1(messageReadyFlag, 1'b1);
      chk1(srq, 1'b1);
      rd(SMQ_OFF_OUTQ, 32'h11);
      rd(SMQ_OFF_OUTQ, 32'h22);
      @(negedge mclk);
      chk1(messageReadyFlag, 1'b0);
      rd(SMQ_OFF_OUTQ, 32'h0);
      // eight responses fill the output queue and close its input
      for (i = 0; i < 8; i++) rsp(32'(i + 5));
      @(negedge mclk);
      chk1(rspReady, 1'b0);
      for (i = 0; i < 8; i++) rd(SMQ_OFF_OUTQ, 32'(i + 5));
      @(negedge mclk);
      chk1(rspReady, 1'b1);
      chk1(messageReadyFlag, 1'b0);
      acc(1'b1, SMQ_OFF_SRE, 32'h0);
      // twelve errors into ten slots: last slot becomes overflow, rest dropped
      for (i = 1; i <= 12; i++) evt(1'b0, 16'(-i));
      rd(SMQ_OFF_STB, 32'h0a04);
      chk1(errorReadyFlag, 1'b1);
      for (i = 1; i <= 9; i++) rd(SMQ_OFF_ERRQ, sx(16'(-i)));
      rd(SMQ_OFF_ERRQ, 32'd350);
      rd(SMQ_OFF_ERRQ, 32'h0);
      @(negedge mclk);
      chk1(errorReadyFlag, 1'b0);
      // default filter: vendor error in, status message out
      evt(1'b1, 16'h00c8);
      evt(1'b0, 16'h0005);
      rd(SMQ_OFF_ERRQ, 32'h5);
      rd(SMQ_OFF_ERRQ, 32'h0);
      // enable range -222..-110, then disable -150
      acc(1'b1, SMQ_OFF_FRANGE, 32'hff92ff22);
      acc(1'b1, SMQ_OFF_FCTRL, 32'h1);
      acc(1'b1, SMQ_OFF_FCTRL, 32'h2);
      rd(SMQ_OFF_FCTRL, 32'h0);
      evt(1'b0, 16'hff6a);
      evt(1'b0, 16'hfed4);
      evt(1'b0, 16'h0005);
      acc(1'b1, SMQ_OFF_FRANGE, 32'hff6aff6a);
      acc(1'b1, SMQ_OFF_FCTRL, 32'h3);
      evt(1'b0, 16'hff6a);
      evt(1'b0, 16'hff88);
      rd(SMQ_OFF_ERRQ, sx(16'hff6a));
      rd(SMQ_OFF_ERRQ, sx(16'hff88));
      rd(SMQ_OFF_ERRQ, 32'h0);
      // preset keeps the queue, clear-status empties it, filter survives both
      evt(1'b0, 16'hff88);
      acc(1'b1, SMQ_OFF_CMD, 32'h2);
      rd(SMQ_OFF_STB, 32'h0104);
      acc(1'b1, SMQ_OFF_CMD, 32'h1);
      rd(SMQ_OFF_STB, 32'h0);
      evt(1'b0, 16'h0005);
      evt(1'b0, 16'hff88);
      rd(SMQ_OFF_STB, 32'h0104);
      acc(1'b1, SMQ_OFF_FCTRL, 32'h1);
      evt(1'b0, 16'hff88);
      rd(SMQ_OFF_STB, 32'h0104);
      // battery buffer full after the averaging count
      acc(1'b1, SMQ_OFF_MEN, 32'h200);
      acc(1'b1, SMQ_OFF_AVG, 32'h3);
      pulse(2);
      chk1(batteryBufferFullFlag, 1'b0);
      pulse(1);
      chk1(batteryBufferFullFlag, 1'b1);
      u_host.pollFull(r, to);
      if (to) hang();
      chk32(r, 32'h200);
      rd(SMQ_OFF_MEVT, 32'h0);
      pulse(3);
      acc(1'b1, SMQ_OFF_CMD, 32'h1);
      rd(SMQ_OFF_MEVT, 32'h0);
      conclude();
   end
endmodule
